// ===== hw/nvber_top.sv
// nonvolatile memory bit error reporting: flags, reset and nmi requests, vectors
// Operation
// R1: uncorrectable error sets uncorrectable flag
// R2: reset enable: uncorrectable error requests reset, cause
// R3: uncorrectable irq enable: raise nmi, load code; here only while reset enable is clear
// R4: correctable irq enable: set flag, nmi, code
// R5: uncorrectable flag survives the caused reset
// R6: software clears both flags via status register
// R7: software disables enables before low power
// R8: software clears flags, restores after wake
// R9: flags stay set until cleared or power-on
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "nvber_regs.svh"
module nvber_top
    import nvber_pkg::*;
(
    // clock and resets
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic por_n,
    // error detector, same clock
    input wire logic uncorr_err,
    input wire logic corr_err,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // system reset and nmi
    output logic system_soft_reset,
    output logic nmi_req
);
    // ==========================================================
    // decode
    logic sel_ctrl;
    logic sel_stat;
    logic sel_rstv;
    logic sel_nmiv;
    assign sel_ctrl = reg_addr == `NVBER_CTRL_OFS;
    assign sel_stat = reg_addr == `NVBER_STAT_OFS;
    assign sel_rstv = reg_addr == `NVBER_RSTV_OFS;
    assign sel_nmiv = reg_addr == `NVBER_NMIV_OFS;

    // ==========================================================
    // control register, cleared by any system reset
    logic [2:0] ctrl_r;
    logic uncorrectable_reset_enable;
    logic uncorrectable_irq_enable;
    logic correctable_irq_enable;
    assign uncorrectable_reset_enable = ctrl_r[`NVBER_CTRL_RSTEN_BIT];
    assign uncorrectable_irq_enable = ctrl_r[`NVBER_CTRL_UIE_BIT];
    assign correctable_irq_enable = ctrl_r[`NVBER_CTRL_CIE_BIT];

    always_ff @(posedge sys_clk) begin
        if (!reset_n || system_soft_reset) begin
            ctrl_r <= `NVBER_CTRL_RESET;
        end else if (reg_wr && sel_ctrl) begin
            ctrl_r <= reg_wdata[2:0];
        end
    end

    // ==========================================================
    // flags: power-on reset only, so they survive the soft reset
    logic uncorrectable_err_flag;
    logic correctable_err_flag;
    logic uflag_clr;
    logic cflag_clr;
    logic cflag_set;
    assign uflag_clr = reg_wr & sel_stat & reg_wdata[`NVBER_STAT_UFLG_BIT]; // [R6]
    assign cflag_clr = reg_wr & sel_stat & reg_wdata[`NVBER_STAT_CFLG_BIT]; // [R6]
    assign cflag_set = corr_err & correctable_irq_enable; // [R4]

    nvber_flag u_uflag (
        .sys_clk(sys_clk),
        .por_n(por_n), // [R5] [R9]
        .set_in(uncorr_err), // [R1]
        .clr_in(uflag_clr),
        .flag_out(uncorrectable_err_flag)
    );

    nvber_flag u_cflag (
        .sys_clk(sys_clk),
        .por_n(por_n), // [R9]
        .set_in(cflag_set),
        .clr_in(cflag_clr),
        .flag_out(correctable_err_flag)
    );

    // ==========================================================
    // soft reset sequencer
    nvber_state_t state_r;
    nvber_state_t state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic rst_trig;
    assign rst_trig = uncorr_err & uncorrectable_reset_enable; // [R2]

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            NVBER_IDLE: begin
                if (rst_trig) begin
                    state_nxt = NVBER_RST;
                    cnt_nxt = `NVBER_RST_PULSE_CYC - 4'h1;
                end
            end
            NVBER_RST: begin
                if (cnt_r == 4'h0) begin
                    state_nxt = NVBER_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            default: begin
                state_nxt = NVBER_IDLE;
                cnt_nxt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_r <= NVBER_IDLE;
            cnt_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign system_soft_reset = state_r == NVBER_RST; // [R2]

    // ==========================================================
    // reset cause vector: kept across soft reset so software can read it
    logic [7:0] rstv_r;
    logic rstv_rd;
    assign rstv_rd = reg_rd & sel_rstv;

    always_ff @(posedge sys_clk) begin
        if (!por_n) begin
            rstv_r <= `NVBER_VEC_NONE;
        end else if (rst_trig && state_r == NVBER_IDLE) begin
            rstv_r <= `NVBER_RST_CODE_UNCORR; // [R2]
        end else if (rstv_rd) begin
            rstv_r <= `NVBER_VEC_NONE;
        end
    end

    // ==========================================================
    // nmi vector: uncorrectable has priority; read clears the pending code
    logic [7:0] nmiv_r;
    logic u_nmi;
    logic c_nmi;
    logic nmiv_rd;
    logic c_load;
    assign u_nmi = uncorr_err & uncorrectable_irq_enable & ~rst_trig; // [R3]
    assign c_nmi = corr_err & correctable_irq_enable; // [R4]
    assign nmiv_rd = reg_rd & sel_nmiv;
    // a read that empties a pending uncorrectable code must not swallow a new correctable one
    assign c_load = c_nmi & ((nmiv_r != `NVBER_NMI_CODE_UNCORR) | nmiv_rd); // [R4]

    always_ff @(posedge sys_clk) begin
        if (!reset_n || system_soft_reset) begin
            nmiv_r <= `NVBER_VEC_NONE;
        end else if (u_nmi) begin
            nmiv_r <= `NVBER_NMI_CODE_UNCORR; // [R3]
        end else if (c_load) begin
            nmiv_r <= `NVBER_NMI_CODE_CORR; // [R4]
        end else if (nmiv_rd) begin
            nmiv_r <= `NVBER_VEC_NONE;
        end
    end

    // pending code held means nmi stays requested
    assign nmi_req = nmiv_r != `NVBER_VEC_NONE; // [R3] [R4]

    // ==========================================================
    // read data, one cycle after strobe; unmapped reads zero
    logic [31:0] rd_mux;
    assign rd_mux = sel_ctrl ? {29'h0, ctrl_r} :
                    sel_stat ? {30'h0, correctable_err_flag, uncorrectable_err_flag} :
                    sel_rstv ? {24'h0, rstv_r} :
                    sel_nmiv ? {24'h0, nmiv_r} : 32'h0;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 32'h0;
        end
    end
endmodule

// ===== hw/nvber_regs.svh
// register offsets, field positions, reset values and cause codes of the error reporter
`ifndef NVBER_REGS_SVH
`define NVBER_REGS_SVH

// ==========================================================
// register offsets (byte addresses)
`define NVBER_CTRL_OFS 8'h00
`define NVBER_STAT_OFS 8'h04
`define NVBER_RSTV_OFS 8'h08
`define NVBER_NMIV_OFS 8'h0C

// ==========================================================
// error_control_reg fields
`define NVBER_CTRL_RSTEN_BIT 0
`define NVBER_CTRL_UIE_BIT 1
`define NVBER_CTRL_CIE_BIT 2
`define NVBER_CTRL_RESET 3'h0

// ==========================================================
// error_status_reg fields (write 1 to clear)
`define NVBER_STAT_UFLG_BIT 0
`define NVBER_STAT_CFLG_BIT 1

// ==========================================================
// vector codes
`define NVBER_VEC_NONE 8'h00
`define NVBER_RST_CODE_UNCORR 8'h24
`define NVBER_NMI_CODE_UNCORR 8'h02
`define NVBER_NMI_CODE_CORR 8'h04

// ==========================================================
// reset pulse length in cycles
`define NVBER_RST_PULSE_CYC 4'h4

`endif

// ===== hw/nvber_pkg.sv
// types of the error reporter
package nvber_pkg;
    typedef enum logic [1:0] {
        NVBER_IDLE = 2'b00,
        NVBER_RST = 2'b01
    } nvber_state_t;
endpackage

// ===== hw/nvber_flag.sv
// sticky flag cell: hardware set beats software clear
`timescale 1ns/1ps
module nvber_flag
    import nvber_pkg::*;
(
    // clock and power-on reset
    input wire logic sys_clk,
    input wire logic por_n,
    // set and clear
    input wire logic set_in,
    input wire logic clr_in,
    // state
    output logic flag_out
);
    logic flag_r;
    logic flag_nxt;

    // set wins over a clear in the same cycle
    assign flag_nxt = set_in | (flag_r & ~clr_in);
    assign flag_out = flag_r;

    always_ff @(posedge sys_clk) begin
        if (!por_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end
endmodule

// ===== bench/nvber_det_model.sv
// error detector model: one-cycle error reports after a chosen delay
`timescale 1ns/1ps
module nvber_det_model (
    // clock
    input wire logic sys_clk,
    // reports toward the reporter
    output logic uncorr_err,
    output logic corr_err
);
    initial begin
        uncorr_err = 1'b0;
        corr_err = 1'b0;
    end
    // gap of zero answers at once, larger gaps model a slow read path
    task report(input int gap, input logic u, input logic c);
        repeat (gap) @(posedge sys_clk);
        uncorr_err <= u;
        corr_err <= c;
        @(posedge sys_clk);
        uncorr_err <= 1'b0;
        corr_err <= 1'b0;
    endtask
endmodule

// ===== bench/nvber_asserts.sv
// port checker of the error reporter
`timescale 1ns/1ps
module nvber_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // watched ports
    input wire logic uncorr_err,
    input wire logic corr_err,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic system_soft_reset,
    input wire logic nmi_req
);
    // ========
    // shadow of the enables; soft reset wipes them
    logic [2:0] ctl_r;
    wire u_rst = uncorr_err && ctl_r[0] && !system_soft_reset;
    wire u_nmi = uncorr_err && ctl_r[1] && !ctl_r[0];
    wire c_nmi = corr_err && ctl_r[2];
    wire sts_rd = reg_rd && reg_addr == 8'h04;
    always_ff @(posedge sys_clk) begin
        if (!reset_n || system_soft_reset) ctl_r <= 3'h0;
        else if (reg_wr && reg_addr == 8'h00) ctl_r <= reg_wdata[2:0];
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    rst_pulse_a: assert property (u_rst |=>
        system_soft_reset[*4] ##1 !system_soft_reset) else $error("bad reset pulse");
    rst_cause_a: assert property ($rose(system_soft_reset) |-> $past(u_rst))
        else $error("stray reset");
    nmi_uncorr_a: assert property (u_nmi && !system_soft_reset |=> nmi_req)
        else $error("no nmi");
    nmi_corr_a: assert property (c_nmi && !system_soft_reset |=> nmi_req)
        else $error("no nmi");
    nmi_quiet_a: assert property (!nmi_req && !u_nmi && !c_nmi |=> !nmi_req)
        else $error("stray nmi");
    uflag_set_a: assert property (uncorr_err ##1 !reg_wr ##1 sts_rd |=> reg_rdata[0])
        else $error("flag not set");
    vec_clear_a: assert property (reg_rd && reg_addr == 8'h0C && !uncorr_err && !corr_err
        |=> !nmi_req) else $error("nmi held");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("rdata not idle");
endmodule
bind nvber_top nvber_asserts u_nvber_asserts (.sys_clk(sys_clk), .reset_n(reset_n),
    .uncorr_err(uncorr_err), .corr_err(corr_err), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .system_soft_reset(system_soft_reset), .nmi_req(nmi_req));

// ===== bench/nvber_top_tb.sv
// bench of the error reporter
`timescale 1ns/1ps
module nvber_top_tb;
    logic sys_clk, reset_n, por_n, reg_wr, reg_rd, uncorr_err, corr_err, srst, nmi_req;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    int errors = 0, num_checks = 0, cyc = 0, n;
    nvber_det_model u_nvber_det_model (.sys_clk(sys_clk), .uncorr_err(uncorr_err),
        .corr_err(corr_err));
    nvber_top u_nvber_top (.sys_clk(sys_clk), .reset_n(reset_n), .por_n(por_n),
        .uncorr_err(uncorr_err), .corr_err(corr_err), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .system_soft_reset(srst), .nmi_req(nmi_req));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ========
    // hang guard, runs take under a hundred cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            wrap_up();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task t_reset();
        // both reset and uncorrectable nmi enabled: the reset must win
        wr(8'h00, 32'h3);
        u_nvber_det_model.report(0, 1'b1, 1'b0);
        n = 0;
        repeat (8) begin
            #1 if (srst === 1'b1) n++;
            @(posedge sys_clk);
        end
        chk(n, 4);
        chk(nmi_req, 1'b0);
        rd(8'h04, 32'h1);
        rd(8'h08, 32'h24);
        rd(8'h08, 32'h0);
        rd(8'h00, 32'h0);
        $display("reset test done");
    endtask
    task t_nmi();
        // start from a clear flag so the set is really seen
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h2);
        u_nvber_det_model.report(0, 1'b1, 1'b0);
        rd(8'h04, 32'h1);
        chk(nmi_req, 1'b1);
        rd(8'h0C, 32'h2);
        chk(nmi_req, 1'b0);
        wr(8'h00, 32'h4);
        u_nvber_det_model.report(3, 1'b0, 1'b1);
        rd(8'h04, 32'h3);
        rd(8'h0C, 32'h4);
        $display("nmi test done");
    endtask
    task t_clear();
        wr(8'h04, 32'h3);
        rd(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        u_nvber_det_model.report(0, 1'b1, 1'b1);
        rd(8'h04, 32'h1);
        chk(nmi_req, 1'b0);
        wr(8'h04, 32'h3);
        // clear and a new error at the same edge: the error must stick
        fork
            wr(8'h04, 32'h1);
            u_nvber_det_model.report(1, 1'b1, 1'b0);
        join
        rd(8'h04, 32'h1);
        rd(8'h10, 32'h0);
        $display("clear test done");
    endtask
    task wrap_up();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        por_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        por_n <= 1'b1;
        t_reset();
        t_nmi();
        t_clear();
        wrap_up();
    end
endmodule
